// [logic/slss_device.sv]
// Converter end: APB control registers, link state machine and lane framing.
// Assumes the receiver end on pclk; the link inputs still pass two flip-flops.
`include "slss_map.svh"
module slss_device #(
  parameter int KM1_W   = `SLSS_KM1_W,   // Multiframe length field width
  parameter int DECIM_W = `SLSS_DECIM_W  // Decimation field width
) (
  input  wire logic                    pclk,     // 50 MHz clock
  input  wire logic                    presetn,  // Async reset, low active
  input  wire logic                    psel,     // APB select
  input  wire logic                    penable,  // APB access phase
  input  wire logic                    pwrite,   // APB direction
  input  wire logic [11:0]             paddr,    // APB byte address
  input  wire logic [31:0]             pwdata,   // APB write data
  output logic      [31:0]             prdata,   // APB read data
  output logic                         pready,   // APB ready, always high
  output logic                         pslverr,  // APB error on unmapped address
  input  wire logic [`SLSS_RAW_W-1:0]  raw_sample, // Raw converter sample
  input  wire logic [`SLSS_IQ_W-1:0]   i_sample, // Down-converted I
  input  wire logic [`SLSS_IQ_W-1:0]   q_sample, // Down-converted Q
  slss_link_if.dev                     link      // Link to the receiver
);
  // Elaboration check: the register layout only fits the default field widths
  if (KM1_W != `SLSS_KM1_W || DECIM_W != `SLSS_DECIM_W) begin : g_bad_width
    $error("slss_device: field widths must match the register layout");
  end
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic               en_ff;
  logic               det_ff;
  logic [DECIM_W-1:0] decim_ff;
  logic               scr_ff;
  logic [KM1_W-1:0]   km1_ff;
  logic               ddr_ff;
  logic [15:0]        cal_cnt_ff;
  logic               phase_ok_ff;
  slss_pkg::slss_link_type st_ff;
  slss_pkg::slss_link_type nxt_st;
  logic wr;
  logic rd_ok;
  logic [31:0] rd_mux;
  // Address match helper
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit
  assign wr     = psel && penable && pwrite;
  assign pready = 1'b1;
  assign rd_ok  = hit(paddr, `SLSS_REG_CTRL) || hit(paddr, `SLSS_REG_CFG)
               || hit(paddr, `SLSS_REG_STAT);
  assign pslverr = psel && penable && !rd_ok;
  // Control register: enable, calibration trigger, phase reference need
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff  <= 1'b0;
      det_ff <= 1'b1;
    end else if (wr && hit(paddr, `SLSS_REG_CTRL)) begin
      en_ff  <= pwdata[`SLSS_CTRL_EN_BIT];
      det_ff <= pwdata[`SLSS_CTRL_DET_BIT];
    end
  end
  // Configuration accepted only while the link is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decim_ff <= `SLSS_DECIM_RESET;
      scr_ff   <= 1'b0;
      km1_ff   <= `SLSS_KM1_RESET;
      ddr_ff   <= 1'b0;
    end else if (wr && hit(paddr, `SLSS_REG_CFG) && !en_ff) begin
      decim_ff <= pwdata[`SLSS_CFG_DECIM_LSB +: DECIM_W];
      scr_ff   <= pwdata[`SLSS_CFG_SCR_BIT];
      km1_ff   <= pwdata[`SLSS_CFG_KM1_LSB +: KM1_W];
      ddr_ff   <= pwdata[`SLSS_CFG_DDR_BIT];
    end
  end
  // Calibration busy counter, started by the trigger bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_cnt_ff <= 16'h0000;
    end else if (wr && hit(paddr, `SLSS_REG_CTRL) && pwdata[`SLSS_CTRL_CAL_BIT]) begin
      cal_cnt_ff <= `SLSS_CAL_CYC;
    end else if (cal_cnt_ff != 16'h0000) begin
      cal_cnt_ff <= cal_cnt_ff - 16'h0001;
    end
  end
  // Read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(paddr, `SLSS_REG_CTRL)) begin
      rd_mux[`SLSS_CTRL_EN_BIT]  = en_ff;
      rd_mux[`SLSS_CTRL_CAL_BIT] = (cal_cnt_ff != 16'h0000);
      rd_mux[`SLSS_CTRL_DET_BIT] = det_ff;
    end else if (hit(paddr, `SLSS_REG_CFG)) begin
      rd_mux[`SLSS_CFG_DECIM_LSB +: DECIM_W] = decim_ff;
      rd_mux[`SLSS_CFG_SCR_BIT]              = scr_ff;
      rd_mux[`SLSS_CFG_KM1_LSB +: KM1_W]     = km1_ff;
      rd_mux[`SLSS_CFG_DDR_BIT]              = ddr_ff;
    end else if (hit(paddr, `SLSS_REG_STAT)) begin
      rd_mux[2:0] = st_ff;
      rd_mux[4]   = phase_ok_ff;
    end
  end
  // Read data captured in the setup phase, so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Link inputs pass two flip-flops
  logic sysref_m_ff, sysref_s_ff, sysref_d_ff;
  logic sync_m_ff, sync_s_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysref_m_ff <= 1'b0;
      sysref_s_ff <= 1'b0;
      sysref_d_ff <= 1'b0;
      sync_m_ff   <= 1'b1;
      sync_s_ff   <= 1'b1;
    end else begin
      sysref_m_ff <= link.sysref;
      sysref_s_ff <= sysref_m_ff;
      sysref_d_ff <= sysref_s_ff;
      sync_m_ff   <= link.sync_n;
      sync_s_ff   <= sync_m_ff;
    end
  end
  // Multiframe phase counter, reset on phase reference rise
  logic [KM1_W-1:0] mf_cnt_ff;
  logic             mf_wrap;
  logic             sysref_rise;
  assign sysref_rise = sysref_s_ff && !sysref_d_ff;
  assign mf_wrap     = (mf_cnt_ff == km1_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mf_cnt_ff   <= '0;
      phase_ok_ff <= 1'b0;
    end else if (!en_ff) begin
      mf_cnt_ff   <= '0;
      phase_ok_ff <= 1'b0;
    end else if (sysref_rise) begin
      mf_cnt_ff   <= '0;
      phase_ok_ff <= 1'b1;
    end else begin
      mf_cnt_ff <= mf_wrap ? '0 : mf_cnt_ff + 1'b1;
    end
  end
  // Link state machine
  logic [2:0] ila_cnt_ff;
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      slss_pkg::SLSS_OFF: if (cal_cnt_ff == 16'h0000) nxt_st = slss_pkg::SLSS_WAIT;
      slss_pkg::SLSS_WAIT: begin
        if (!sync_s_ff && (phase_ok_ff || !det_ff)) nxt_st = slss_pkg::SLSS_CGS;
      end
      slss_pkg::SLSS_CGS: begin
        if (sync_s_ff && mf_wrap) nxt_st = slss_pkg::SLSS_ILA;
      end
      slss_pkg::SLSS_ILA: begin
        if (!sync_s_ff) nxt_st = slss_pkg::SLSS_CGS;
        else if (mf_wrap && ila_cnt_ff == 3'(`SLSS_ILA_MF - 1)) nxt_st = slss_pkg::SLSS_DATA;
      end
      default: if (!sync_s_ff) nxt_st = slss_pkg::SLSS_CGS;
    endcase
    if (!en_ff) nxt_st = slss_pkg::SLSS_OFF;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= slss_pkg::SLSS_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // Alignment multiframe counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ila_cnt_ff <= 3'h0;
    end else if (st_ff != slss_pkg::SLSS_ILA) begin
      ila_cnt_ff <= 3'h0;
    end else if (mf_wrap) begin
      ila_cnt_ff <= ila_cnt_ff + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Data format and lane output, registered
  logic [31:0] sample_word;
  always_comb begin
    if (decim_ff == `SLSS_DECIM_BYPASS) begin
      sample_word = {20'h0_0000, raw_sample};
    end else begin
      sample_word = {1'b0, i_sample, 1'b0, q_sample};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.lane_valid <= 1'b0;
      link.lane_kind  <= slss_pkg::SLSS_SYM_IDLE;
      link.lane_data  <= 32'h0000_0000;
      link.lane_start <= 1'b0;
    end else begin
      link.lane_valid <= (st_ff != slss_pkg::SLSS_OFF) && (st_ff != slss_pkg::SLSS_WAIT);
      link.lane_start <= (mf_cnt_ff == '0);
      case (st_ff)
        slss_pkg::SLSS_CGS: begin
          link.lane_kind <= slss_pkg::SLSS_SYM_K;
          link.lane_data <= 32'h0000_00bc;
        end
        slss_pkg::SLSS_ILA: begin
          link.lane_kind <= slss_pkg::SLSS_SYM_ILA;
          link.lane_data <= {8'h00, ddr_ff, scr_ff, 1'b0, 5'(km1_ff), 2'b00,
                             6'(decim_ff), 5'h00, ila_cnt_ff};
        end
        slss_pkg::SLSS_DATA: begin
          link.lane_kind <= slss_pkg::SLSS_SYM_DATA;
          link.lane_data <= sample_word;
        end
        default: begin
          link.lane_kind <= slss_pkg::SLSS_SYM_IDLE;
          link.lane_data <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule : slss_device

// [logic/slss_link_if.sv]
// Link between the converter side and the receiver/clock source side.
// Assumes both ends share pclk and presetn.
`include "slss_map.svh"
interface slss_link_if;
  logic                      sysref;      // Phase reference pulse, high active
  logic                      sync_n;      // Sync request, low active
  logic                      lane_valid;  // Lane word valid
  slss_pkg::slss_sym_type    lane_kind;   // Kind of lane word
  logic [`SLSS_DATA_W-1:0]   lane_data;   // Lane word
  logic                      lane_start;  // First word of a multiframe
  // Converter end
  modport dev (input sysref, input sync_n,
               output lane_valid, output lane_kind, output lane_data, output lane_start);
  // Receiver and clock source end
  modport rcv (output sysref, output sync_n,
               input lane_valid, input lane_kind, input lane_data, input lane_start);
endinterface : slss_link_if

// [logic/slss_map.svh]
// Constants for the serial link startup sequencer: control fields and timing.
// Assumes inclusion by the package and by both ends; definitions only.
`ifndef SLSS_MAP_SVH
`define SLSS_MAP_SVH
// Control field widths and reset values
`define SLSS_DECIM_W        6
`define SLSS_DECIM_BYPASS   6'h01
`define SLSS_DECIM_RESET    6'h01
`define SLSS_KM1_W          5
`define SLSS_KM1_RESET      5'h1f
`define SLSS_FPM_RESET      8'h04
// Sample widths
`define SLSS_RAW_W          12
`define SLSS_IQ_W           15
`define SLSS_DATA_W         32
// Initial lane alignment: multiframes sent before data
`define SLSS_ILA_MF         4
// Calibration busy time in cycles
`define SLSS_CAL_CYC        16'h0040
// Controller register offsets (APB byte addresses)
`define SLSS_REG_CTRL       12'h000
`define SLSS_REG_CFG        12'h004
`define SLSS_REG_STAT       12'h008
// CTRL fields
`define SLSS_CTRL_EN_BIT    0
`define SLSS_CTRL_CAL_BIT   1
`define SLSS_CTRL_SYSREF_BIT 2
`define SLSS_CTRL_DET_BIT   3
// CFG fields
`define SLSS_CFG_DECIM_LSB  0
`define SLSS_CFG_SCR_BIT    8
`define SLSS_CFG_KM1_LSB    16
`define SLSS_CFG_DDR_BIT    24
`endif

// [logic/slss_pkg.sv]
// Types shared by both ends of the serial link startup sequencer.
// Assumes slss_map.svh is on the include path.
`include "slss_map.svh"
package slss_pkg;
  // Device link states
  typedef enum logic [2:0] {
    SLSS_OFF   = 3'b000,
    SLSS_WAIT  = 3'b001,
    SLSS_CGS   = 3'b010,
    SLSS_ILA   = 3'b011,
    SLSS_DATA  = 3'b100
  } slss_link_type;
  // Receiver-side states
  typedef enum logic [1:0] {
    SLSS_RX_IDLE = 2'b00,
    SLSS_RX_REQ  = 2'b01,
    SLSS_RX_ILA  = 2'b10,
    SLSS_RX_DATA = 2'b11
  } slss_rx_type;
  // Lane symbol kinds
  typedef enum logic [1:0] {
    SLSS_SYM_IDLE = 2'b00,
    SLSS_SYM_K    = 2'b01,
    SLSS_SYM_ILA  = 2'b10,
    SLSS_SYM_DATA = 2'b11
  } slss_sym_type;
endpackage : slss_pkg

// [logic/slss_receiver.sv]
// Receiver and clock source end: issues phase reference and sync requests.
// Assumes the device end on the same clock; inputs from it need no synchroniser.
`include "slss_map.svh"
module slss_receiver (
  input  wire logic             pclk,          // 50 MHz clock
  input  wire logic             presetn,       // Async reset, low active
  slss_link_if.rcv              link,          // Link to the device
  input  wire logic             sysref_req,    // Pulse: send one phase reference edge
  input  wire logic             start_req,     // Level: begin link bring-up
  output logic                  rx_aligned,    // Normal data being received
  output logic [`SLSS_DATA_W-1:0] rx_data,     // Last received data word
  output logic                  rx_data_valid  // Pulse: rx_data updated
);
  ////////////////////////////////////////////////////////////////////////////
  slss_pkg::slss_rx_type st_ff;
  slss_pkg::slss_rx_type nxt_st;
  logic sysref_ff;
  // Phase reference: sysref_req delayed by one flip-flop, same width as the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysref_ff <= 1'b0;
    end else begin
      sysref_ff <= sysref_req;
    end
  end
  assign link.sysref = sysref_ff;
  // Sync request low from request until code groups are seen
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      slss_pkg::SLSS_RX_IDLE: if (start_req) nxt_st = slss_pkg::SLSS_RX_REQ;
      slss_pkg::SLSS_RX_REQ: begin
        if (link.lane_valid && link.lane_kind == slss_pkg::SLSS_SYM_K) begin
          nxt_st = slss_pkg::SLSS_RX_ILA;
        end
      end
      slss_pkg::SLSS_RX_ILA: begin
        if (link.lane_valid && link.lane_kind == slss_pkg::SLSS_SYM_DATA) begin
          nxt_st = slss_pkg::SLSS_RX_DATA;
        end
      end
      default: if (!link.lane_valid) nxt_st = slss_pkg::SLSS_RX_IDLE;
    endcase
    if (!start_req) nxt_st = slss_pkg::SLSS_RX_IDLE;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= slss_pkg::SLSS_RX_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign link.sync_n = (st_ff != slss_pkg::SLSS_RX_REQ);
  assign rx_aligned  = (st_ff == slss_pkg::SLSS_RX_DATA);
  // Capture data words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data       <= '0;
      rx_data_valid <= 1'b0;
    end else begin
      rx_data_valid <= link.lane_valid && link.lane_kind == slss_pkg::SLSS_SYM_DATA;
      if (link.lane_valid && link.lane_kind == slss_pkg::SLSS_SYM_DATA) begin
        rx_data <= link.lane_data;
      end
    end
  end
endmodule : slss_receiver

// [testbench/slss_link_checker.sv]
// Concurrent checks on the lane and reference signals between both ends.
// Assumes one clock and reset shared by both ends; sits beside the link.
`include "slss_map.svh"
module slss_link_checker (
  input wire logic                    pclk,       // Clock
  input wire logic                    presetn,    // Async reset, low active
  input wire logic                    sysref,     // Phase reference pulse
  input wire logic                    sync_n,     // Sync request, low active
  input wire logic                    lane_valid, // Lane word valid
  input wire slss_pkg::slss_sym_type  lane_kind,  // Lane word kind
  input wire logic [`SLSS_DATA_W-1:0] lane_data,  // Lane word
  input wire logic                    lane_start  // First word of multiframe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ILA_MF = `SLSS_ILA_MF;
  logic       ila_now;
  logic       data_now;
  logic [3:0] ila_cnt_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // Word kind decode
  assign ila_now  = lane_valid && (lane_kind == slss_pkg::SLSS_SYM_ILA);
  assign data_now = lane_valid && (lane_kind == slss_pkg::SLSS_SYM_DATA);
  // Counts multiframe starts seen during the alignment sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ila_cnt_ff <= 4'h0;
    end else if (ila_now) begin
      ila_cnt_ff <= ila_cnt_ff + {3'b000, lane_start};
    end else begin
      ila_cnt_ff <= 4'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_k_code;
    lane_valid && lane_kind == slss_pkg::SLSS_SYM_K |-> lane_data[7:0] == 8'hbc;
  endproperty
  a_k_code: assert property (p_k_code)
    else $error("sync word carries wrong code");
  property p_ila_after_k;
    ila_now && !$past(ila_now) |-> $past(lane_valid) && $past(lane_kind) == slss_pkg::SLSS_SYM_K;
  endproperty
  a_ila_after_k: assert property (p_ila_after_k)
    else $error("alignment sequence not preceded by sync words");
  property p_ila_needs_sync;
    ila_now && !$past(ila_now) |-> sync_n && $past(sync_n, 3);
  endproperty
  a_ila_needs_sync: assert property (p_ila_needs_sync)
    else $error("alignment sequence began while sync was requested");
  property p_ila_on_boundary;
    ila_now && !$past(ila_now) |-> lane_start;
  endproperty
  a_ila_on_boundary: assert property (p_ila_on_boundary)
    else $error("alignment sequence off the multiframe boundary");
  property p_data_no_gap;
    data_now && !$past(data_now) |-> $past(ila_now) && lane_start;
  endproperty
  a_data_no_gap: assert property (p_data_no_gap)
    else $error("gap between alignment sequence and data");
  property p_ila_length;
    data_now && !$past(data_now) |-> ila_cnt_ff == 4'(ILA_MF);
  endproperty
  a_ila_length: assert property (p_ila_length)
    else $error("alignment sequence has wrong multiframe count");
  property p_sync_low_no_data;
    !sync_n [*5] |-> !data_now;
  endproperty
  a_sync_low_no_data: assert property (p_sync_low_no_data)
    else $error("data sent while sync held low");
  property p_sysref_pulse;
    $rose(sysref) |=> !sysref;
  endproperty
  a_sysref_pulse: assert property (p_sysref_pulse)
    else $error("phase reference pulse longer than one cycle");
endmodule : slss_link_checker

// [testbench/tb_top.sv]
// Testbench: both link ends joined, device driven over APB.
// Assumes the design files and slss_map.svh on the include path.
`include "slss_map.svh"
`define TB_CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rx_data;
  logic        sysref_req, start_req, rx_aligned, rx_data_valid;
  logic [11:0] raw_sample;
  logic [14:0] i_sample, q_sample;
  int          fail_count, compares;
  ////////////////////////////////////////////////////////////////////////////////
  slss_link_if link ();
  slss_device slss_device_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .raw_sample(raw_sample), .i_sample(i_sample), .q_sample(q_sample),
    .link(link));
  slss_receiver slss_receiver_i (.pclk(pclk), .presetn(presetn), .link(link),
    .sysref_req(sysref_req), .start_req(start_req), .rx_aligned(rx_aligned),
    .rx_data(rx_data), .rx_data_valid(rx_data_valid));
  slss_link_checker slss_link_checker_i (.pclk(pclk), .presetn(presetn), .sysref(link.sysref),
    .sync_n(link.sync_n), .lane_valid(link.lane_valid), .lane_kind(link.lane_kind),
    .lane_data(link.lane_data), .lane_start(link.lane_start));
  // Clock generation
  always #10 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  // Prints the verdict and ends the run
  task automatic report_and_stop();
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // One APB transfer; result lands in rd and err
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin `TB_CHK(pready, 1'b1) report_and_stop(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Configure, calibrate, enable and wait for the first data word
  task automatic run_link(input logic [31:0] cfg, input logic [31:0] ctrl, input logic pulse,
                          input logic [31:0] exp);
    int n = 0;
    apb(1'b1, `SLSS_REG_CTRL, 32'h0000_0000);
    apb(1'b1, `SLSS_REG_CFG, cfg);
    apb(1'b0, `SLSS_REG_CFG, 32'h0000_0000);
    `TB_CHK(rd, cfg)
    apb(1'b1, `SLSS_REG_CTRL, 32'h0000_0002);
    apb(1'b0, `SLSS_REG_CTRL, 32'h0000_0000);
    `TB_CHK(rd[1], 1'b1)
    while (rd[1] !== 1'b0 && n < 100) begin apb(1'b0, `SLSS_REG_CTRL, 32'h0); n++; end
    `TB_CHK(rd[1], 1'b0)
    if (rd[1] !== 1'b0) report_and_stop();
    apb(1'b1, `SLSS_REG_CTRL, ctrl);
    apb(1'b1, `SLSS_REG_CFG, 32'h0000_0000);
    apb(1'b0, `SLSS_REG_CFG, 32'h0000_0000);
    `TB_CHK(rd, cfg)
    if (pulse) begin
      @(posedge pclk) sysref_req <= 1'b1;
      @(posedge pclk) sysref_req <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    start_req <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end
      while (!(rx_aligned === 1'b1 && rx_data_valid === 1'b1) && n < 5000);
    `TB_CHK(rx_data_valid, 1'b1)
    `TB_CHK(rx_aligned, 1'b1)
    if (rx_aligned !== 1'b1 || rx_data_valid !== 1'b1) report_and_stop();
    `TB_CHK(rx_data, exp)
    apb(1'b0, `SLSS_REG_STAT, 32'h0000_0000);
    `TB_CHK(rd[2:0], slss_pkg::SLSS_DATA)
    if (pulse) `TB_CHK(rd[4], 1'b1)
    else `TB_CHK(rd[4], 1'b0)
  endtask : run_link
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000;
    pwdata = 32'h0000_0000; sysref_req = 0; start_req = 0; fail_count = 0; compares = 0;
    raw_sample = 12'ha5c; i_sample = 15'h1234; q_sample = 15'h4321;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SLSS_REG_CFG, 32'h0000_0000);
    `TB_CHK(rd, 32'h001f_0001)
    apb(1'b0, 12'h00c, 32'h0000_0000);
    `TB_CHK(err, 1'b1)
    `TB_CHK(rd, 32'h0000_0000)
    run_link(32'h0103_0101, 32'h0000_0009, 1'b1, {20'h0_0000, raw_sample});
    start_req <= 1'b0;
    apb(1'b1, `SLSS_REG_CTRL, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    `TB_CHK(link.lane_valid, 1'b0)
    start_req <= 1'b1;
    repeat (30) @(posedge pclk);
    `TB_CHK(link.lane_valid, 1'b0)
    apb(1'b0, `SLSS_REG_STAT, 32'h0000_0000);
    `TB_CHK(rd[2:0], slss_pkg::SLSS_OFF)
    start_req <= 1'b0;
    repeat (10) @(posedge pclk);
    run_link(32'h0003_0004, 32'h0000_0001, 1'b0,
             {1'b0, i_sample, 1'b0, q_sample});
    report_and_stop();
  end
endmodule : tb_top
